//--- hw/sfe_params.svh
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses on APB)
`define SFE_ADDR_CONFIG 12'h000
`define SFE_ADDR_PROTECT 12'h004
`define SFE_ADDR_READ_DATA 12'h008
`define SFE_ADDR_RX_DATA 12'h00c
`define SFE_ADDR_STATUS 12'h010

// ==========================================================
// Field positions
`define SFE_CFG_QUAD_ENABLE 0
`define SFE_CFG_PAUSE_RESET_SEL 1
`define SFE_ST_SELECTED 0
`define SFE_ST_BUSY 1
`define SFE_ST_PAUSED 2
`define SFE_ST_IN_RESET 3
`define SFE_ST_HW_PROTECTED 4
`define SFE_ST_WP_ACTIVE 5
`define SFE_ST_LAST_OP_LSB 8

// ==========================================================
// Reset values
`define SFE_CONFIG_RESET 2'h0
`define SFE_PROTECT_RESET 7'h00
`define SFE_READ_DATA_RESET 8'h00

// ==========================================================
// Instruction codes
`define SFE_OP_WRITE_STATUS 8'h01
`define SFE_OP_PROGRAM 8'h02
`define SFE_OP_READ 8'h03
`define SFE_OP_READ_STATUS 8'h05
`define SFE_OP_ERASE 8'h20
`define SFE_OP_QUAD_PROGRAM 8'h32
`define SFE_OP_DUAL_READ 8'h3b
`define SFE_OP_QUAD_READ 8'h6b

// ==========================================================
// Timing
`define SFE_CLK_PERIOD_NS 20
`define SFE_BUSY_TIME_NS 2000

`endif

//--- hw/sfe_pkg.sv
package sfe_pkg;

	typedef enum {
		ST_IDLE,
		ST_INSTR,
		ST_DATA_IN,
		ST_DATA_OUT,
		ST_IGNORE
	} sfe_state_e;

	typedef logic [7:0] sfe_byte_t;
	typedef logic [2:0] sfe_lanes_t;

endpackage

//--- hw/sfe_pin_if.sv
`timescale 1ns/1ns
`default_nettype none

interface sfe_pin_if;
	logic [7:0] raw;
	logic [7:0] filt;
	modport sync(input raw, output filt);
	modport user(output raw, input filt);
endinterface

`default_nettype wire

//--- hw/sfe_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Three-stage pin synchroniser; a bit changes once stages two and three agree.
module sfe_pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Pins
	sfe_pin_if.sync pins
);
	logic [7:0] s1_reg;
	logic [7:0] s2_reg;
	logic [7:0] s3_reg;
	logic [7:0] filt_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_reg <= 8'h00;
			s2_reg <= 8'h00;
			s3_reg <= 8'h00;
		end else begin
			s1_reg <= pins.raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			filt_reg <= 8'h00;
		end else begin
			filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
		end
	end

	assign pins.filt = filt_reg;
endmodule // sfe_pin_sync

`default_nettype wire

//--- hw/sfe_front_end.sv
`include "sfe_params.svh"
`timescale 1ns/1ns
`default_nettype none

module sfe_front_end #(
	parameter int BUSY_TIME_NS = `SFE_BUSY_TIME_NS
) (
	// System clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Flash pins
	input wire logic SERIAL_CLK,
	input wire logic SELECT_N,
	input wire logic HW_RESET_N,
	input wire logic [3:0] DATA_LINE_IN,
	output logic [3:0] DATA_LINE_OUT,
	output logic [3:0] DATA_LINE_OE_N
);
	localparam int BUSY_CYCLES = (BUSY_TIME_NS + `SFE_CLK_PERIOD_NS - 1) / `SFE_CLK_PERIOD_NS;

	// ==========================================================
	// Helpers
	function automatic sfe_pkg::sfe_byte_t shift_in(input sfe_pkg::sfe_byte_t sh,
			input logic [3:0] dl, input sfe_pkg::sfe_lanes_t lanes);
		unique case (lanes)
			3'd2: shift_in = {sh[5:0], dl[1], dl[0]};
			3'd4: shift_in = {sh[3:0], dl};
			default: shift_in = {sh[6:0], dl[0]};
		endcase
	endfunction

	function automatic logic [3:0] out_bits(input sfe_pkg::sfe_byte_t sh,
			input sfe_pkg::sfe_lanes_t lanes);
		unique case (lanes)
			3'd2: out_bits = {2'b00, sh[7], sh[6]};
			3'd4: out_bits = sh[7:4];
			default: out_bits = {2'b00, sh[7], 1'b0};
		endcase
	endfunction

	function automatic logic [3:0] lane_oe_n(input sfe_pkg::sfe_lanes_t lanes);
		unique case (lanes)
			3'd2: lane_oe_n = 4'hc;
			3'd4: lane_oe_n = 4'h0;
			default: lane_oe_n = 4'hd;
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers
	sfe_pin_if pins ();
	assign pins.raw = {1'b0, HW_RESET_N, SELECT_N, SERIAL_CLK, DATA_LINE_IN};
	sfe_pin_sync u_sync (
		.clk(CLK),
		.reset_n(RESET_N),
		.pins(pins.sync)
	);

	logic [3:0] dl_f;
	logic sclk_f;
	logic sel_n_f;
	logic hw_rst_n_f;
	assign dl_f = pins.filt[3:0];
	assign sclk_f = pins.filt[4];
	assign sel_n_f = pins.filt[5];
	assign hw_rst_n_f = pins.filt[6];

	// ==========================================================
	// State
	sfe_pkg::sfe_state_e state_reg;
	sfe_pkg::sfe_byte_t op_reg;
	sfe_pkg::sfe_byte_t in_sh_reg;
	sfe_pkg::sfe_byte_t out_sh_reg;
	sfe_pkg::sfe_byte_t rx_reg;
	sfe_pkg::sfe_byte_t read_data_reg;
	sfe_pkg::sfe_lanes_t lanes_reg;
	logic [3:0] bit_cnt_reg;
	logic [2:0] rx_count_reg;
	logic [1:0] config_reg;
	logic [7:1] protect_reg;
	logic sclk_prev_reg;
	logic sel_n_prev_reg;
	logic armed_reg;
	logic paused_reg;
	logic [15:0] busy_cnt_reg;
	logic busy;
	logic [3:0] dq_out_reg;
	logic [3:0] dq_oe_n_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// ==========================================================
	// Pin roles
	logic quad_enable_bit;
	logic pause_reset_sel;
	logic status_lock_mode;
	logic wp_active;
	logic hw_protected;
	logic shared_reset;
	logic dev_reset;
	logic pause_req;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;
	sfe_pkg::sfe_byte_t status_byte;
	sfe_pkg::sfe_byte_t op_next;
	logic [3:0] bit_sum;

	assign quad_enable_bit = config_reg[`SFE_CFG_QUAD_ENABLE];
	assign pause_reset_sel = config_reg[`SFE_CFG_PAUSE_RESET_SEL];
	assign status_lock_mode = protect_reg[7];
	// Line 2 is write-protect only while the quad enable bit is clear.
	assign wp_active = !quad_enable_bit && !dl_f[2];
	assign hw_protected = wp_active && status_lock_mode && (|protect_reg[4:1]);
	assign shared_reset = !quad_enable_bit && pause_reset_sel && !dl_f[3];
	assign dev_reset = !hw_rst_n_f || shared_reset;
	assign pause_req = !quad_enable_bit && !pause_reset_sel && !dl_f[3] && !sel_n_f;
	assign sclk_rise = sclk_f && !sclk_prev_reg;
	assign sclk_fall = !sclk_f && sclk_prev_reg;
	assign sel_fall = !sel_n_f && sel_n_prev_reg;
	assign sel_rise = sel_n_f && !sel_n_prev_reg;
	assign busy = busy_cnt_reg != 16'h0000;
	assign status_byte = {protect_reg, busy};
	assign op_next = {in_sh_reg[6:0], dl_f[0]};
	assign bit_sum = bit_cnt_reg + {1'b0, lanes_reg};

	// ==========================================================
	// Edge history
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			sclk_prev_reg <= 1'b0;
			sel_n_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_f;
			sel_n_prev_reg <= sel_n_f;
		end
	end

	// The select must be seen high before a fall can open a frame.
	always_ff @(posedge CLK) begin
		if (!RESET_N || dev_reset) begin
			armed_reg <= 1'b0;
		end else if (sel_n_f) begin
			armed_reg <= 1'b1;
		end
	end

	// Outside deselect and reset, pause changes only while the serial clock is low, so a high clock
	// defers it to the next falling edge.
	always_ff @(posedge CLK) begin
		if (!RESET_N || dev_reset || sel_n_f) begin
			paused_reg <= 1'b0;
		end else if (!sclk_f) begin
			paused_reg <= pause_req;
		end
	end

	// ==========================================================
	// Frame engine
	always_ff @(posedge CLK) begin
		if (!RESET_N || dev_reset) begin
			state_reg <= sfe_pkg::ST_IDLE;
			op_reg <= 8'h00;
			in_sh_reg <= 8'h00;
			out_sh_reg <= 8'h00;
			rx_reg <= 8'h00;
			lanes_reg <= 3'd1;
			bit_cnt_reg <= 4'h0;
			rx_count_reg <= 3'd0;
			dq_out_reg <= 4'h0;
			dq_oe_n_reg <= 4'hf;
		end else if (sel_n_f) begin
			state_reg <= sfe_pkg::ST_IDLE;
			dq_oe_n_reg <= 4'hf;
		end else if (sel_fall && armed_reg) begin
			// Either clock idle level is fine: the instruction phase only counts rises.
			state_reg <= sfe_pkg::ST_INSTR;
			lanes_reg <= 3'd1;
			bit_cnt_reg <= 4'h0;
			rx_count_reg <= 3'd0;
			dq_oe_n_reg <= 4'hf;
		end else if (paused_reg) begin
			dq_oe_n_reg <= 4'hf;
		end else begin
			unique case (state_reg)
				sfe_pkg::ST_IDLE, sfe_pkg::ST_IGNORE: begin
					dq_oe_n_reg <= 4'hf;
				end
				sfe_pkg::ST_INSTR: begin
					if (sclk_rise) begin
						in_sh_reg <= op_next;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == 4'h7) begin
							op_reg <= op_next;
							bit_cnt_reg <= 4'h0;
							state_reg <= sfe_pkg::ST_IGNORE;
							if (op_next == `SFE_OP_READ_STATUS) begin
								state_reg <= sfe_pkg::ST_DATA_OUT;
								out_sh_reg <= status_byte;
								lanes_reg <= 3'd1;
							end else if (!busy) begin
								unique case (op_next)
									`SFE_OP_READ: begin
										state_reg <= sfe_pkg::ST_DATA_OUT;
										out_sh_reg <= read_data_reg;
										lanes_reg <= 3'd1;
									end
									`SFE_OP_DUAL_READ: begin
										state_reg <= sfe_pkg::ST_DATA_OUT;
										out_sh_reg <= read_data_reg;
										lanes_reg <= 3'd2;
									end
									`SFE_OP_QUAD_READ: begin
										if (quad_enable_bit) begin
											state_reg <= sfe_pkg::ST_DATA_OUT;
											out_sh_reg <= read_data_reg;
											lanes_reg <= 3'd4;
										end
									end
									`SFE_OP_QUAD_PROGRAM: begin
										if (quad_enable_bit) begin
											state_reg <= sfe_pkg::ST_DATA_IN;
											lanes_reg <= 3'd4;
										end
									end
									`SFE_OP_WRITE_STATUS, `SFE_OP_PROGRAM, `SFE_OP_ERASE: begin
										state_reg <= sfe_pkg::ST_DATA_IN;
										lanes_reg <= 3'd1;
									end
									default: begin
										state_reg <= sfe_pkg::ST_IGNORE;
									end
								endcase
							end
						end
					end
				end
				sfe_pkg::ST_DATA_IN: begin
					if (sclk_rise) begin
						in_sh_reg <= shift_in(in_sh_reg, dl_f, lanes_reg);
						bit_cnt_reg <= bit_sum;
						if (bit_sum == 4'h8) begin
							rx_reg <= shift_in(in_sh_reg, dl_f, lanes_reg);
							bit_cnt_reg <= 4'h0;
							if (rx_count_reg != 3'd7) begin
								rx_count_reg <= rx_count_reg + 3'd1;
							end
						end
					end
				end
				sfe_pkg::ST_DATA_OUT: begin
					dq_oe_n_reg <= lane_oe_n(lanes_reg);
					if (sclk_fall) begin
						dq_out_reg <= out_bits(out_sh_reg, lanes_reg);
						bit_cnt_reg <= bit_sum;
						if (bit_sum == 4'h8) begin
							bit_cnt_reg <= 4'h0;
							out_sh_reg <= (op_reg == `SFE_OP_READ_STATUS) ? status_byte
								: read_data_reg;
						end else begin
							out_sh_reg <= out_sh_reg << lanes_reg;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Deselect commits
	logic in_frame_end;
	logic wrsr_commit;
	logic work_commit;
	assign in_frame_end = sel_rise && state_reg == sfe_pkg::ST_DATA_IN;
	assign wrsr_commit = in_frame_end && op_reg == `SFE_OP_WRITE_STATUS
		&& rx_count_reg != 3'd0 && !(status_lock_mode && wp_active);
	assign work_commit = in_frame_end && !hw_protected
		&& (((op_reg == `SFE_OP_PROGRAM || op_reg == `SFE_OP_QUAD_PROGRAM)
		&& rx_count_reg >= 3'd4) || (op_reg == `SFE_OP_ERASE && rx_count_reg >= 3'd3));

	// Busy runs on regardless of the select; only a reset cuts it short.
	always_ff @(posedge CLK) begin
		if (!RESET_N || dev_reset) begin
			busy_cnt_reg <= 16'h0000;
		end else if (wrsr_commit || work_commit) begin
			busy_cnt_reg <= 16'(BUSY_CYCLES);
		end else if (busy) begin
			busy_cnt_reg <= busy_cnt_reg - 16'h0001;
		end
	end

	// ==========================================================
	// APB slave: one wait state, so every output is registered.
	logic apb_access;
	logic apb_commit;
	logic addr_ok;
	assign apb_access = PSEL && PENABLE && !pready_reg;
	assign apb_commit = PSEL && PENABLE && pready_reg;
	assign addr_ok = PADDR == `SFE_ADDR_CONFIG || PADDR == `SFE_ADDR_PROTECT
		|| PADDR == `SFE_ADDR_READ_DATA || PADDR == `SFE_ADDR_RX_DATA
		|| PADDR == `SFE_ADDR_STATUS;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			config_reg <= `SFE_CONFIG_RESET;
			protect_reg <= `SFE_PROTECT_RESET;
			read_data_reg <= `SFE_READ_DATA_RESET;
		end else begin
			if (apb_commit && PWRITE && PADDR == `SFE_ADDR_CONFIG) begin
				config_reg <= PWDATA[1:0];
			end
			if (apb_commit && PWRITE && PADDR == `SFE_ADDR_READ_DATA) begin
				read_data_reg <= PWDATA[7:0];
			end
			// A status write from the pins overrides a same-cycle bus write.
			if (wrsr_commit) begin
				protect_reg <= rx_reg[7:1];
			end else if (apb_commit && PWRITE && PADDR == `SFE_ADDR_PROTECT) begin
				protect_reg <= PWDATA[7:1];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= apb_access;
			pslverr_reg <= apb_access && !addr_ok;
			prdata_reg <= 32'h0000_0000;
			if (apb_access && !PWRITE) begin
				unique case (PADDR)
					`SFE_ADDR_CONFIG: prdata_reg <= {30'h0, config_reg};
					`SFE_ADDR_PROTECT: prdata_reg <= {24'h0, protect_reg, 1'b0};
					`SFE_ADDR_READ_DATA: prdata_reg <= {24'h0, read_data_reg};
					`SFE_ADDR_RX_DATA: prdata_reg <= {24'h0, rx_reg};
					`SFE_ADDR_STATUS: begin
						prdata_reg[`SFE_ST_SELECTED] <= state_reg != sfe_pkg::ST_IDLE;
						prdata_reg[`SFE_ST_BUSY] <= busy;
						prdata_reg[`SFE_ST_PAUSED] <= paused_reg;
						prdata_reg[`SFE_ST_IN_RESET] <= dev_reset;
						prdata_reg[`SFE_ST_HW_PROTECTED] <= hw_protected;
						prdata_reg[`SFE_ST_WP_ACTIVE] <= wp_active;
						prdata_reg[`SFE_ST_LAST_OP_LSB +: 8] <= op_reg;
					end
					default: prdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign DATA_LINE_OUT = dq_out_reg;
	assign DATA_LINE_OE_N = dq_oe_n_reg;
endmodule // sfe_front_end

`default_nettype wire

//--- dv/sfe_front_end_sva.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Port checker
module sfe_front_end_sva (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Flash pins
	input wire logic SERIAL_CLK,
	input wire logic SELECT_N,
	input wire logic HW_RESET_N,
	input wire logic [3:0] DATA_LINE_OUT,
	input wire logic [3:0] DATA_LINE_OE_N
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	// Cycles since the serial clock was last seen falling, saturating.
	logic sclk_reg;
	logic [3:0] since_fall_reg;
	always_ff @(posedge CLK) begin
		sclk_reg <= SERIAL_CLK;
	end
	always_ff @(posedge CLK) begin
		if (!RESET_N || (sclk_reg && !SERIAL_CLK))
			since_fall_reg <= 4'h0;
		else if (since_fall_reg != 4'hf)
			since_fall_reg <= since_fall_reg + 4'h1;
	end

	sequence access_s;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence answer_s;
		PREADY ##1 !PREADY;
	endsequence
	sequence deselected_s;
		SELECT_N [*8];
	endsequence

	apb_wait_state_a: assert property (access_s |=> answer_s)
		else $error("APB answer not one cycle after access");
	ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE))
		else $error("PREADY without access");
	error_pairs_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("PSLVERR without PREADY or with data");
	rdata_quiet_a: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("PRDATA not zero outside answer");
	deselect_float_a: assert property (deselected_s |-> DATA_LINE_OE_N == 4'hf)
		else $error("line driven while deselected");
	reset_float_a: assert property (!HW_RESET_N [*6] |-> DATA_LINE_OE_N == 4'hf)
		else $error("line driven in reset");
	lane_set_a: assert property (DATA_LINE_OE_N inside {4'hf, 4'hd, 4'hc, 4'h0})
		else $error("illegal set of driven lines");
	out_after_fall_a: assert property (!DATA_LINE_OE_N[1] && $stable(DATA_LINE_OE_N)
		&& !$stable(DATA_LINE_OUT) |-> since_fall_reg <= 4'h7)
		else $error("output changed away from a falling edge");
endmodule // sfe_front_end_sva

`default_nettype wire

//--- dv/sfe_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Behavioural SPI host
module sfe_host_model (
	// Host drive
	output logic sck,
	output logic sel_n,
	output logic [3:0] line,
	// Device drive
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe_n
);
	logic mosi = 1'b0;
	logic wp_n = 1'b1;
	logic hold_n = 1'b1;
	logic cpol = 1'b0;
	logic drove = 1'b0;
	logic [3:0] paused_oe = 4'h0;

	// An undriven line1 shows the inverse of its last value, so stale data never matches.
	assign line = {dev_oe_n[3] ? hold_n : dev_out[3], dev_oe_n[2] ? wp_n : dev_out[2],
		dev_oe_n[1] ? ~dev_out[1] : dev_out[1], dev_oe_n[0] ? mosi : dev_out[0]};

	initial begin
		sck = 1'b0;
		sel_n = 1'b1;
	end
	always @(dev_oe_n) begin
		if (dev_oe_n != 4'hf)
			drove = 1'b1;
	end

	// ==========================================================
	// One frame
	// Read data is sampled late in the high phase, since the synchronised device
	// changes its output close to the following rise.
	task automatic frame(input logic [7:0] op, input logic [7:0] wd, input int nwr,
			input int nrd, input int lanes, input int pause_at, output logic [7:0] rd);
		rd = 8'h00;
		#7;
		sck = cpol;
		#80;
		sel_n = 1'b0;
		drove = 1'b0;
		#80;
		for (int i = 0; i < 8 * (nwr + 1); i++) begin
			sck = 1'b0;
			mosi = (i < 8) ? op[7 - i] : wd[7 - i % 8];
			#80;
			sck = 1'b1;
			#80;
		end
		mosi = ~mosi;
		for (int i = 0; i < 8 * nrd / lanes; i++) begin
			sck = 1'b0;
			#80;
			if (i == pause_at) begin
				hold_n = 1'b0;
				#200;
				paused_oe = dev_oe_n;
				sck = 1'b1;
				#80;
				sck = 1'b0;
				#80;
				hold_n = 1'b1;
				#200;
			end
			sck = 1'b1;
			#80;
			rd = lanes == 4 ? {rd[3:0], line} : lanes == 2 ? {rd[5:0], line[1:0]}
				: {rd[6:0], line[1]};
		end
		sck = cpol;
		#80;
		sel_n = 1'b1;
		// The tail gives back the opening offset, so every frame keeps one phase
		// against the system clock and no pin moves on its sampling edge.
		#393;
	endtask
endmodule // sfe_host_model

`default_nettype wire

//--- dv/testbench.sv
`include "sfe_params.svh"
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic hw_reset_n = 1'b1;
	wire sck;
	wire sel_n;
	wire [3:0] line;
	wire [3:0] dout;
	wire [3:0] oe_n;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rdv;
	logic err;
	logic [7:0] sb;

	always #10 clk = ~clk;

	sfe_front_end #(.BUSY_TIME_NS(20000)) uut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SERIAL_CLK(sck), .SELECT_N(sel_n),
		.HW_RESET_N(hw_reset_n), .DATA_LINE_IN(line), .DATA_LINE_OUT(dout),
		.DATA_LINE_OE_N(oe_n));
	sfe_host_model host (.sck(sck), .sel_n(sel_n), .line(line), .dev_out(dout),
		.dev_oe_n(oe_n));

	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic status_is(input logic [7:0] exp);
		host.frame(`SFE_OP_READ_STATUS, 8'h00, 0, 1, 1, -1, sb);
		chk({24'h0, sb}, {24'h0, exp});
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic regs_test;
		apb(1'b0, `SFE_ADDR_CONFIG, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b1, `SFE_ADDR_PROTECT, 32'h6d);
		apb(1'b0, `SFE_ADDR_PROTECT, 32'h0);
		chk(rdv, 32'h6c);
		apb(1'b1, `SFE_ADDR_READ_DATA, 32'ha5);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task automatic read_test;
		for (int m = 0; m < 2; m++) begin
			host.cpol = m[0];
			host.frame(`SFE_OP_READ, 8'h00, 0, 2, 1, -1, sb);
			chk({24'h0, sb}, 32'ha5);
		end
		host.cpol = 1'b0;
	endtask
	task automatic status_test;
		host.frame(`SFE_OP_WRITE_STATUS, 8'h9a, 1, 0, 1, -1, sb);
		apb(1'b0, `SFE_ADDR_RX_DATA, 32'h0);
		chk(rdv, 32'h9a);
		// A committed status write is busy for a while, and the lock bit with line 2 low refuses writes.
		status_is(8'h9b);
		#22000;
		host.wp_n <= 1'b0;
		host.frame(`SFE_OP_WRITE_STATUS, 8'h00, 1, 0, 1, -1, sb);
		status_is(8'h9a);
		apb(1'b1, `SFE_ADDR_CONFIG, 32'h1);
		host.frame(`SFE_OP_WRITE_STATUS, 8'h80, 1, 0, 1, -1, sb);
		apb(1'b1, `SFE_ADDR_CONFIG, 32'h0);
		host.wp_n <= 1'b1;
		status_is(8'h81);
		#22000;
	endtask
	task automatic busy_test;
		host.frame(`SFE_OP_PROGRAM, 8'h3c, 4, 0, 1, -1, sb);
		status_is(8'h81);
		host.frame(`SFE_OP_READ, 8'h00, 0, 1, 1, -1, sb);
		chk({31'h0, host.drove}, 32'h0);
		#22000;
		status_is(8'h80);
		apb(1'b1, `SFE_ADDR_PROTECT, 32'h82);
		host.wp_n <= 1'b0;
		host.frame(`SFE_OP_ERASE, 8'h00, 3, 0, 1, -1, sb);
		status_is(8'h82);
		host.wp_n <= 1'b1;
		apb(1'b1, `SFE_ADDR_PROTECT, 32'h80);
	endtask
	task automatic quad_test;
		host.frame(`SFE_OP_QUAD_READ, 8'h00, 0, 1, 4, -1, sb);
		chk({31'h0, host.drove}, 32'h0);
		apb(1'b1, `SFE_ADDR_CONFIG, 32'h1);
		host.frame(`SFE_OP_QUAD_READ, 8'h00, 0, 2, 4, -1, sb);
		chk({24'h0, sb}, 32'ha5);
		host.frame(`SFE_OP_DUAL_READ, 8'h00, 0, 2, 2, -1, sb);
		chk({24'h0, sb}, 32'ha5);
		apb(1'b1, `SFE_ADDR_CONFIG, 32'h0);
	endtask
	task automatic pause_test;
		host.frame(`SFE_OP_READ, 8'h00, 0, 1, 1, 3, sb);
		chk({28'h0, host.paused_oe}, 32'hf);
		chk({24'h0, sb}, 32'ha5);
	endtask
	task automatic reset_test;
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, `SFE_ADDR_CONFIG, {30'h0, ~m[0], 1'b0});
			host.frame(`SFE_OP_PROGRAM, 8'h11, 4, 0, 1, -1, sb);
			@(posedge clk);
			host.hold_n <= m[0];
			hw_reset_n <= ~m[0];
			repeat (60) @(posedge clk);
			apb(1'b0, `SFE_ADDR_STATUS, 32'h0);
			chk({30'h0, rdv[`SFE_ST_IN_RESET], rdv[`SFE_ST_BUSY]}, 32'h2);
			host.hold_n <= 1'b1;
			hw_reset_n <= 1'b1;
			repeat (10) @(posedge clk);
			status_is(8'h80);
		end
	endtask

	// ==========================================================
	// Main sequence and watchdog
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		regs_test();
		read_test();
		status_test();
		busy_test();
		quad_test();
		pause_test();
		reset_test();
		end_sim();
	end
endmodule // testbench

bind sfe_front_end sfe_front_end_sva chk_i (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.SERIAL_CLK(SERIAL_CLK), .SELECT_N(SELECT_N), .HW_RESET_N(HW_RESET_N),
	.DATA_LINE_OUT(DATA_LINE_OUT), .DATA_LINE_OE_N(DATA_LINE_OE_N));

`default_nettype wire
